// [verilog/fcpwm_unit.sv]
/*
  Four-channel pulse-width unit with Avalon-MM register slave.
  Assumes one 100 MHz clock, synchronous active-high reset and a master
  that holds each request until waitrequest is seen low.
*/
// Operation
// - Mode zero: counter restarts after maximum count
// - Mode bit 8: one shot, run cycles, halt
// - Bits 7..4 set channel output polarity
// - Bits 3..0 enable channels 3..0
// - Ten-bit maximum count register, resets zero
// - Counter steps on selected tick only
`timescale 1ns/1ns
`default_nettype none
module fcpwm_unit
(
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic [fcpwm_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [fcpwm_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [fcpwm_pkg::DATA_W-1:0]  avs_readdata,
  output logic                               avs_waitrequest,
  output logic      [fcpwm_pkg::NCH-1:0]     pwm_out
);
  import fcpwm_pkg::*;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [REG_W-1:0]  ctrl_r;           // Control
  logic [CNT_W-1:0]  max_r;            // Maximum count
  logic [REG_W-1:0]  cyc_r;            // One-shot cycle count
  logic [CNT_W-1:0]  duty_r [NCH];     // Per-channel duty
  logic [CNT_W-1:0]  cnt_r;            // Pulse counter
  logic [REG_W-1:0]  done_r;           // Finished counter cycles
  logic [NCH-1:0]    out_r;            // Output pins
  logic              wait_r;           // Waitrequest
  logic [DATA_W-1:0] rdata_r;          // Read data

  fcpwm_tick_if tk ();
  fcpwm_tick u_tick (.mclk(mclk), .sys_rst(sys_rst), .tk(tk.div));

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  wire               req     = avs_read | avs_write;    // Request held
  wire               acc     = req & ~wait_r;           // Accepted edge
  wire               wr      = avs_write & ~wait_r;     // Write takes effect
  wire               hit_ctl = (avs_address == ADR_CTRL);
  wire               hit_max = (avs_address == ADR_MAX);
  wire               hit_cyc = (avs_address == ADR_CYC);
  wire               hit_st  = (avs_address == ADR_STAT);
  wire [REG_W-1:0]   wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [REG_W-1:0]   wdat    = avs_writedata[REG_W-1:0];
  wire [REG_W-1:0]   ctl_new = ((ctrl_r & ~wmask) | (wdat & wmask)) & CTL_MASK;
  wire               wr_ctl  = wr & hit_ctl;
  wire               go      = wr_ctl & ctl_new[CTL_RUN] & ~ctrl_r[CTL_RUN];
  wire               run     = ctrl_r[CTL_RUN];
  wire               oneshot = ctrl_r[CTL_MODE];
  wire               wrap    = run & tk.tick & (cnt_r >= max_r);
  wire [REG_W-1:0]   done_p1 = REG_W'(done_r + 16'h0001);
  wire               finish  = wrap & oneshot & (done_p1 >= cyc_r);
  wire [NCH-1:0]     hit_dy;
  wire [NCH-1:0]     on_now;
  wire [NCH-1:0]     en      = ctrl_r[CTL_EN_LSB +: NCH];
  wire [NCH-1:0]     pol     = ctrl_r[CTL_POL_LSB +: NCH];
  logic [REG_W-1:0]  rd_mux;

  assign tk.sel          = ctrl_r[CTL_SEL_LSB +: SEL_W];
  assign avs_waitrequest = wait_r;
  assign avs_readdata    = rdata_r;
  assign pwm_out         = out_r;

  // Per-channel decode and active phase
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      assign hit_dy[i] = (avs_address == ADDR_W'(ADR_DUTY0 + ADR_STEP * i));
      assign on_now[i] = run & (cnt_r < duty_r[i]);
      // Duty register write
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
          duty_r[i] <= DUTY_RST;
        else if (wr & hit_dy[i])
          duty_r[i] <= (duty_r[i] & ~wmask[CNT_W-1:0]) | (wdat[CNT_W-1:0] & wmask[CNT_W-1:0]);
      end
      // Output: active level is the polarity bit, idle is its inverse
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
          out_r[i] <= 1'b1;
        else
          out_r[i] <= (en[i] & on_now[i]) ? pol[i] : ~pol[i];
      end
    end
  endgenerate

  // Read multiplexer, unmapped addresses read zero
  always_comb
  begin
    rd_mux = '0;
    if (hit_ctl)
      rd_mux = ctrl_r;
    else if (hit_max)
      rd_mux = {6'h00, max_r};
    else if (hit_cyc)
      rd_mux = cyc_r;
    else if (hit_st)
      rd_mux = {5'h00, run, cnt_r};
    else
      for (int j = 0; j < NCH; j++)
        if (hit_dy[j])
          rd_mux = {6'h00, duty_r[j]};
  end

  // ***************************************************************
  // Bus handshake: one wait cycle per request
  // ***************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end
    else
    begin
      wait_r  <= ~(req & wait_r);
      rdata_r <= (req & wait_r) ? {16'h0000, rd_mux} : rdata_r;
    end
  end

  // Control; a software write wins over the one-shot clear
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ctrl_r <= CTL_RST;
    else if (wr_ctl)
      ctrl_r <= ctl_new;
    else if (finish)
      ctrl_r[CTL_RUN] <= 1'b0;
  end

  // Maximum count and cycle count
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      max_r <= MAX_RST;
      cyc_r <= CYC_RST;
    end
    else
    begin
      if (wr & hit_max)
        max_r <= (max_r & ~wmask[CNT_W-1:0]) | (wdat[CNT_W-1:0] & wmask[CNT_W-1:0]);
      if (wr & hit_cyc)
        cyc_r <= (cyc_r & ~wmask) | (wdat & wmask);
    end
  end

  // ***************************************************************
  // Counter: steps on tick, wraps at maximum count
  // ***************************************************************
  always_ff @(posedge mclk)
  begin
    if (sys_rst | go)
    begin
      cnt_r  <= '0;
      done_r <= '0;
    end
    else if (wrap)
    begin
      cnt_r  <= '0;
      done_r <= done_p1;
    end
    else if (run & tk.tick)
      cnt_r  <= CNT_W'(cnt_r + 10'h001);
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_cont_wrap;
    wrap & ~oneshot & ~wr_ctl |=> cnt_r == '0 && run;
  endproperty
  a_cont_wrap: assert property (p_cont_wrap) else $error("continuous wrap failed");

  property p_shot_stop;
    finish & ~wr_ctl |=> !run ##1 $stable(cnt_r);
  endproperty
  a_shot_stop: assert property (p_shot_stop) else $error("one shot did not halt");

  property p_pol_on;
    en[0] & on_now[0] |=> out_r[0] == $past(pol[0]);
  endproperty
  a_pol_on: assert property (p_pol_on) else $error("active level wrong");

  property p_en_off;
    !en[1] |=> out_r[1] == !$past(pol[1]);
  endproperty
  a_en_off: assert property (p_en_off) else $error("disabled channel not idle");

  property p_max_wr;
    wr & hit_max & (&avs_byteenable[1:0]) |=> max_r == $past(wdat[CNT_W-1:0]);
  endproperty
  a_max_wr: assert property (p_max_wr) else $error("max count write lost");

  property p_tick_only;
    !tk.tick & !go |=> $stable(cnt_r);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("counter moved without tick");

  property p_idle_stop;
    !run & !go |=> $stable(cnt_r) && out_r == ~$past(pol);
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("idle unit not at rest");

  property p_bus_ans;
    req & wait_r |=> !wait_r ##1 wait_r;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");

  c_wrap:   cover property (wrap & ~oneshot);
  c_finish: cover property (finish);
  c_pulse:  cover property (out_r[0] ##1 !out_r[0]);
endmodule
`default_nettype wire

// [verilog/fcpwm_pkg.sv]
/*
  Package of the four-channel pulse unit: register offsets, control
  field positions, reset values and the tick divider settings.
  Assumes a 100 MHz mclk and a 16-bit register space that sits in the low
  half of 32-bit Avalon-MM words.
*/
`default_nettype none
package fcpwm_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NCH      = 4;   // Channel count
  localparam int CNT_W    = 10;  // Pulse counter width
  localparam int REG_W    = 16;  // Register width
  localparam int ADDR_W   = 16;  // Byte address width
  localparam int DATA_W   = 32;  // Bus data width
  localparam int SEL_W    = 2;   // Tick rate select width
  localparam int DIV_W    = 3;   // Tick divider width

  // ***************************************************************
  // Register byte addresses
  // ***************************************************************
  localparam logic [ADDR_W-1:0] ADR_CTRL   = 16'hC0E4; // Control
  localparam logic [ADDR_W-1:0] ADR_MAX    = 16'hC0E8; // Maximum count
  localparam logic [ADDR_W-1:0] ADR_CYC    = 16'hC0EC; // One-shot cycle count
  localparam logic [ADDR_W-1:0] ADR_DUTY0  = 16'hC0F0; // Channel 0 duty
  localparam logic [ADDR_W-1:0] ADR_STEP   = 16'h0004; // Duty register stride
  localparam logic [ADDR_W-1:0] ADR_STAT   = 16'hC100; // Status

  // ***************************************************************
  // Control fields
  // ***************************************************************
  localparam int CTL_EN_LSB  = 0;  // Channel enables [3:0]
  localparam int CTL_POL_LSB = 4;  // Channel polarities [7:4]
  localparam int CTL_MODE    = 8;  // 1 = one shot, 0 = continuous
  localparam int CTL_SEL_LSB = 9;  // Tick rate select [10:9]
  localparam int CTL_RUN     = 15; // Run bit, cleared at one-shot end
  localparam logic [REG_W-1:0] CTL_MASK  = 16'h87FF; // Implemented bits
  localparam logic [REG_W-1:0] CTL_RST   = 16'h0000; // Control reset
  localparam logic [CNT_W-1:0] MAX_RST   = 10'h000;  // Max count reset
  localparam logic [REG_W-1:0] CYC_RST   = 16'h0000; // Cycle count reset
  localparam logic [CNT_W-1:0] DUTY_RST  = 10'h000;  // Duty reset

  // ***************************************************************
  // Tick divider: one tick every 2**sel mclk cycles
  // ***************************************************************
  localparam logic [DIV_W-1:0] DIV_ONE   = 3'h1;
  localparam logic [DIV_W-1:0] DIV_ZERO  = 3'h0;

endpackage
`default_nettype wire

// [verilog/fcpwm_tick_if.sv]
/*
  Carrier between the pulse unit and its tick divider: rate select out,
  tick enable back.
  Assumes both ends run on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
interface fcpwm_tick_if;
  logic [fcpwm_pkg::SEL_W-1:0] sel;  // Tick rate select
  logic                        tick; // One-cycle count enable
  modport unit (output sel, input tick);
  modport div  (input sel, output tick);
endinterface
`default_nettype wire

// [verilog/fcpwm_tick.sv]
/*
  Tick divider: produces a one-cycle enable every 2**sel mclk cycles.
  Assumes sel is a register output of the unit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module fcpwm_tick
(
  input  wire logic   mclk,
  input  wire logic   sys_rst,
  fcpwm_tick_if.div   tk
);
  import fcpwm_pkg::*;

  logic [DIV_W-1:0] div_r;    // Free-running divider
  logic [DIV_W-1:0] div_nxt;  // Next divider value
  logic [DIV_W-1:0] div_top;  // Last count of a period
  logic             tick_r;   // Registered tick

  assign div_top = DIV_W'((DIV_ONE << tk.sel) - DIV_ONE);
  assign div_nxt = (div_r >= div_top) ? DIV_ZERO : DIV_W'(div_r + DIV_ONE);
  assign tk.tick = tick_r;

  // Divider and tick register
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      div_r  <= DIV_ZERO;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_nxt;
      tick_r <= (div_r >= div_top);
    end
  end
endmodule
`default_nettype wire

// [verification/fcpwm_load.sv]
/*
  Load model at the pulse pins: tallies the mclk cycles each line is high.
  Assumes the pulse outputs are registered levels on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module fcpwm_load
(
  input  wire logic        mclk,
  input  wire logic        clr,     // Zero all tallies
  input  wire logic [3:0]  pwm_out, // Pulse lines at the pins
  output logic      [31:0] hi_cnt   // Four 8-bit tallies, channel 0 lowest
);
  // ***************************************************************
  // High-time tally
  // ***************************************************************
  // One tally per line; wraps only past 255, far beyond a test window
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (clr)
        hi_cnt[i*8 +: 8] <= 8'h00;
      else
        hi_cnt[i*8 +: 8] <= hi_cnt[i*8 +: 8] + {7'h00, pwm_out[i]};
    end
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
/*
  Testbench of the pulse unit: register access over Avalon-MM and
  measured high times at the pins.
  Assumes the package map; the bus tasks wait on waitrequest with no
  fixed latency, and only the watchdog ends a stuck wait.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s exp=%h got=%h", nm, ex, got); end end
module tb_top;
  import fcpwm_pkg::*;
  logic              mclk, sys_rst, avs_read, avs_write, clr, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic [NCH-1:0]    pwm_out;
  logic [31:0]       hi_cnt;
  logic [15:0]       rd;
  int                n_errors, check_count;

  fcpwm_unit dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out));
  fcpwm_load load (.mclk(mclk), .clr(clr), .pwm_out(pwm_out), .hi_cnt(hi_cnt));

  // ***************************************************************
  // Clock and watchdog
  // ***************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // A hang counts as a failure
  initial
  begin
    #200000;
    n_errors++;
    test_done;
  end

  // ***************************************************************
  // Bus and measurement tasks
  // ***************************************************************
  // One request held until waitrequest is seen low, then one idle edge
  task automatic bus_op(input logic wr, input logic [15:0] a, input logic [15:0] d);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    // Hold the request until waitrequest is sampled low
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask

  // Read a register and compare its low half
  task automatic chk_rd(input string nm, input logic [15:0] a, input logic [15:0] ex);
    bus_op(1'b0, a, 16'h0000);
    `CHK(nm, ex, rd)
  endtask

  // Optionally write control, then zero the tallies and count 40 samples;
  // clearing after the write keeps the old setting out of the window
  task automatic measure(input logic wr_ctrl, input logic [15:0] ctl);
    if (wr_ctrl)
      bus_op(1'b1, ADR_CTRL, ctl);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (41) @(posedge mclk);
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial
  begin
    logic [7:0] len;
    n_errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    clr = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 16'h0000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h3;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    `CHK("idle_out", 4'hF, pwm_out)
    chk_rd("ctrl_rst", ADR_CTRL, 16'h0000);
    chk_rd("max_rst", ADR_MAX, 16'h0000);
    bus_op(1'b1, ADR_MAX, 16'h03FF);
    chk_rd("max_rw", ADR_MAX, 16'h03FF);
    chk_rd("unmapped", 16'h0F00, 16'h0000);
    bus_op(1'b1, ADR_MAX, 16'h0003);
    bus_op(1'b1, ADR_DUTY0, 16'h0002);
    bus_op(1'b1, ADR_DUTY0 + 16'h000C, 16'h0004);
    bus_op(1'b1, ADR_CYC, 16'h0002);
    // Continuous run, channel 0 only, polarity low on the others
    measure(1'b1, 16'h8011);
    `CHK("cont_ch0", 8'h14, hi_cnt[7:0])
    `CHK("cont_off", 24'h282828, hi_cnt[31:8])
    // Channel 3 enabled at full duty, all polarities high
    measure(1'b1, 16'h80F9);
    `CHK("en_ch3", 8'h28, hi_cnt[31:24])
    `CHK("pol_off", 16'h0000, hi_cnt[23:8])
    // One shot of two cycles at two tick rates
    for (int s = 0; s < 2; s++)
    begin
      bus_op(1'b1, ADR_CTRL, s[0] ? 16'h02F9 : 16'h00F9);
      measure(1'b1, s[0] ? 16'h83F9 : 16'h81F9);
      len = s[0] ? 8'h10 : 8'h08;
      `CHK("shot_len", 1'b1, hi_cnt[31:24] >= len - 8'h01 && hi_cnt[31:24] <= len)
      `CHK("shot_ch0", 1'b1, hi_cnt[7:0] >= len / 2 - 8'h01 && hi_cnt[7:0] <= len / 2)
      chk_rd("shot_ctrl", ADR_CTRL, s[0] ? 16'h03F9 : 16'h01F9);
      chk_rd("shot_stat", ADR_STAT, 16'h0000);
      `CHK("shot_out", 4'h0, pwm_out)
    end
    test_done;
  end
endmodule
`default_nettype wire
